/* hw/vss_pkg.sv */
package vss_pkg;
  // ************************************************************
  // phase level encoding
  // ************************************************************
  typedef enum logic [1:0] {
    VSS_PH_LOW = 2'b00,
    VSS_PH_MID = 2'b01,
    VSS_PH_HIGH = 2'b10
  } vss_phase_t;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ = 125;
  localparam int OCP_LATCH_US = 50;
  localparam int OCP_LATCH_CYC = OCP_LATCH_US * CLK_MHZ;
  localparam int CFG_CAPTURE_CYC = 16;

  // ************************************************************
  // widths and register map
  // ************************************************************
  localparam int REF_W = 8;
  localparam int MAIN_PH = 3;
  localparam int AUX_PH = 2;
  localparam int CFG_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TARGET = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_REF = 8'h14;
  localparam logic [7:0] REG_CFG = 8'h18;
  localparam int CTRL_SLEW_LSB = 0;
  localparam int SLEW_W = 4;
  localparam logic [REF_W-1:0] TARGET_RST = 8'h80;
  localparam logic [SLEW_W-1:0] SLEW_RST = 4'h3;
  localparam int IRQ_W = 5;
  localparam int IRQ_OCP = 0;
  localparam int IRQ_OCP_SEV = 1;
  localparam int IRQ_UV = 2;
  localparam int IRQ_OV_MAIN = 3;
  localparam int IRQ_OV_AUX = 4;
endpackage

/* hw/vss_sync.sv */
`timescale 1ns/10ps
// ************************************************************
// two-stage synchroniser
// ************************************************************
module vss_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* hw/vss_rail.sv */
`timescale 1ns/10ps
// ************************************************************
// per-rail reference ramp, phase levels and over-voltage handling
// ************************************************************
module vss_rail #(
  parameter int NPH = 3
) (
  // clock
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // sequencing
  input wire logic run,
  input wire logic starting,
  input wire logic step,
  input wire logic [vss_pkg::REF_W-1:0] target,
  // comparators, synchronised
  input wire logic ov_diff,
  input wire logic ov_current_sense_reference,
  input wire logic ov_start,
  input wire logic above_ov,
  input wire logic [NPH-1:0] pwm_req,
  // results
  output logic [vss_pkg::REF_W-1:0] ref_q,
  output logic [2*NPH-1:0] phase,
  output logic ov_trip,
  output logic ov_latched
);
  logic [NPH-1:0] fired_q;
  logic ov_q;
  logic ov_raw;
  logic at_zero;

  assign ov_raw = starting ? ov_start : (ov_diff | ov_current_sense_reference);
  assign ov_trip = run & ov_raw & ~ov_q;
  assign at_zero = (ref_q == '0);
  assign ov_latched = ov_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_q <= '0;
      ov_q <= 1'b0;
      fired_q <= '0;
    end
    else if (ce)
    begin
      if (!run && !ov_q)
      begin
        ref_q <= '0;
        fired_q <= '0;
      end
      else if (ov_trip)
        ov_q <= 1'b1;
      else if (ov_q)
      begin
        if (step && !at_zero)
          ref_q <= ref_q - 1'b1;
      end
      else
      begin
        if (step && ref_q < target)
          ref_q <= ref_q + 1'b1;
        fired_q <= fired_q | pwm_req;
      end
      if (!run && ov_q && !starting)
        ov_q <= ov_q;
    end
  end

  always_comb
  begin
    for (int i = 0; i < NPH; i++)
    begin
      if (ov_q)
      begin
        if (!at_zero && !above_ov)
          phase[2*i +: 2] = vss_pkg::VSS_PH_MID;
        else
          phase[2*i +: 2] = vss_pkg::VSS_PH_LOW;
      end
      else if (!run || !fired_q[i])
        phase[2*i +: 2] = vss_pkg::VSS_PH_MID;
      else if (pwm_req[i])
        phase[2*i +: 2] = vss_pkg::VSS_PH_HIGH;
      else
        phase[2*i +: 2] = vss_pkg::VSS_PH_LOW;
    end
  end
endmodule

/* hw/vss_top.sv */
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/10ps
// Summary of operation
// - hold startup while driver line low
// - after lockouts clear, capture config, phases mid
// - one enable starts both rails, releases line
// - counter ramps reference to target
// - phase stays mid until first pulse
// - disable returns phases to mid
// - current limit starts 50 us latch-off timer
// - severe over-current shuts down at once
// - over-current latch cleared by lockout or enable toggle
// - lockout blocks startup and ignores commands
// - under-voltage drops regulator ready
// - over-voltage drops ready, phases low, ramp down
// - mid level when below falling threshold
// - at zero reference, hold phases low
// - fixed threshold used during startup
// - either over-voltage monitor trips
module vss_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // supplies and enable
  input wire logic vcc_ok,
  input wire logic ramp_supply_sense,
  input wire logic enable,
  input wire logic [vss_pkg::CFG_W-1:0] cfg_pins,
  // driver ready line, open drain style
  input wire logic driver_ready_line_i,
  output logic driver_ready_line_o,
  output logic driver_ready_line_oe,
  // comparators
  input wire logic ilim_trip,
  input wire logic ilim_severe,
  input wire logic [1:0] uv_trip,
  input wire logic [1:0] ov_diff,
  input wire logic [1:0] ov_current_sense_reference,
  input wire logic [1:0] ov_start,
  input wire logic [1:0] above_ov,
  input wire logic [4:0] pwm_req,
  // outputs
  output logic [5:0] phase_main,
  output logic [3:0] phase_aux,
  output logic regulator_ready,
  output logic irq
);
  // ************************************************************
  // synchronisers
  // ************************************************************
  localparam int NS = 21 + vss_pkg::CFG_W;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] syn;
  logic vcc_s, rmp_s, en_s, drv_s, ilim_s, sev_s;
  logic [1:0] uv_s, ovd_s, ovc_s, ovs_s, abv_s;
  logic [4:0] pw_s;
  logic [vss_pkg::CFG_W-1:0] cfg_s;

  assign raw_in = {vcc_ok, ramp_supply_sense, enable, driver_ready_line_i, ilim_trip, ilim_severe,
                   uv_trip, ov_diff, ov_current_sense_reference, ov_start, above_ov, pwm_req, cfg_pins};
  assign {vcc_s, rmp_s, en_s, drv_s, ilim_s, sev_s, uv_s, ovd_s, ovc_s, ovs_s, abv_s,
          pw_s, cfg_s} = syn;

  vss_sync #(.W(NS)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(raw_in),
    .q(syn)
  );

  // ************************************************************
  // sequencer
  // ************************************************************
  typedef enum logic [2:0] {
    ST_LOCKOUT,
    ST_CAPTURE,
    ST_IDLE,
    ST_SOFT,
    ST_RUN,
    ST_OCP_OFF
  } vss_state_t;

  vss_state_t state_q, state_d;
  logic supplies_ok, en_q, en_toggle;
  logic [7:0] cap_cnt_q;
  logic [13:0] ocp_cnt_q;
  logic [vss_pkg::CFG_W-1:0] cfg_q;
  logic run, starting, ramp_done, ocp_fire;
  logic [1:0] ov_trip, ov_lat;
  logic [vss_pkg::REF_W-1:0] ref_main, ref_aux;
  logic [vss_pkg::SLEW_W-1:0] slew_q;
  logic [vss_pkg::REF_W-1:0] target_q;

  assign supplies_ok = vcc_s & rmp_s;
  assign en_toggle = en_q & ~en_s;
  assign run = (state_q == ST_SOFT) || (state_q == ST_RUN);
  assign starting = (state_q == ST_SOFT);
  assign ramp_done = (ref_main == target_q) && (ref_aux == target_q);
  assign ocp_fire = run && (sev_s || (ilim_s && ocp_cnt_q >= 14'(vss_pkg::OCP_LATCH_CYC - 1)));

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_LOCKOUT:
        if (supplies_ok)
          state_d = ST_CAPTURE;
      ST_CAPTURE:
        if (cap_cnt_q == 8'(vss_pkg::CFG_CAPTURE_CYC - 1))
          state_d = ST_IDLE;
      ST_IDLE:
        if (en_s && drv_s)
          state_d = ST_SOFT;
      ST_SOFT:
        if (ocp_fire)
          state_d = ST_OCP_OFF;
        else if (!en_s || !drv_s)
          state_d = ST_IDLE;
        else if (ramp_done)
          state_d = ST_RUN;
      ST_RUN:
        if (ocp_fire)
          state_d = ST_OCP_OFF;
        else if (!en_s || !drv_s)
          state_d = ST_IDLE;
      ST_OCP_OFF:
        if (en_toggle)
          state_d = ST_IDLE;
    endcase
    if (!supplies_ok)
      state_d = ST_LOCKOUT;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_LOCKOUT;
      en_q <= 1'b0;
      cap_cnt_q <= '0;
      cfg_q <= '0;
      ocp_cnt_q <= '0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      en_q <= en_s;
      cap_cnt_q <= (state_q == ST_CAPTURE) ? cap_cnt_q + 8'h01 : 8'h00;
      if (state_q == ST_CAPTURE)
        cfg_q <= cfg_s;
      ocp_cnt_q <= (run && ilim_s) ? ocp_cnt_q + 14'h0001 : 14'h0000;
    end
  end

  // ************************************************************
  // soft-start step timer
  // ************************************************************
  logic [vss_pkg::SLEW_W-1:0] step_cnt_q;
  logic step;
  assign step = (step_cnt_q == slew_q);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      step_cnt_q <= '0;
    else if (ce)
      step_cnt_q <= step ? '0 : step_cnt_q + 1'b1;
  end

  // ************************************************************
  // rails; over-voltage latch survives a driver-line drop, cleared by enable toggle or lockout
  // ************************************************************
  logic rail_rstn, rail_clr_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rail_clr_q <= 1'b0;
    else if (ce)
      rail_clr_q <= en_toggle | ~supplies_ok;
  end

  assign rail_rstn = presetn & ~rail_clr_q;

  vss_rail #(.NPH(vss_pkg::MAIN_PH)) u_main (
    .pclk(pclk),
    .presetn(rail_rstn),
    .ce(ce),
    .run(run),
    .starting(starting),
    .step(step),
    .target(target_q),
    .ov_diff(ovd_s[0]),
    .ov_current_sense_reference(ovc_s[0]),
    .ov_start(ovs_s[0]),
    .above_ov(abv_s[0]),
    .pwm_req(pw_s[2:0]),
    .ref_q(ref_main),
    .phase(phase_main),
    .ov_trip(ov_trip[0]),
    .ov_latched(ov_lat[0])
  );

  vss_rail #(.NPH(vss_pkg::AUX_PH)) u_aux (
    .pclk(pclk),
    .presetn(rail_rstn),
    .ce(ce),
    .run(run),
    .starting(starting),
    .step(step),
    .target(target_q),
    .ov_diff(ovd_s[1]),
    .ov_current_sense_reference(ovc_s[1]),
    .ov_start(ovs_s[1]),
    .above_ov(abv_s[1]),
    .pwm_req(pw_s[4:3]),
    .ref_q(ref_aux),
    .phase(phase_aux),
    .ov_trip(ov_trip[1]),
    .ov_latched(ov_lat[1])
  );

  // ************************************************************
  // outputs
  // ************************************************************
  logic rdy_q, drv_en_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdy_q <= 1'b0;
      drv_en_q <= 1'b0;
    end
    else if (ce)
    begin
      rdy_q <= (state_q == ST_RUN) && !(|uv_s) && !(|ov_lat) && !(|ov_trip);
      drv_en_q <= en_s && (state_d inside {ST_IDLE, ST_SOFT, ST_RUN});
    end
  end

  assign regulator_ready = rdy_q;
  // released line floats high via pull-up; we drive low unless enabled and headed for idle, soft-start or run
  assign driver_ready_line_o = 1'b0;
  assign driver_ready_line_oe = ~drv_en_q;

  // ************************************************************
  // apb registers and interrupt
  // ************************************************************
  logic [vss_pkg::IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev;
  logic wr, rd_ok;
  logic [31:0] rd_mux;

  assign irq_ev = {ov_trip[1], ov_trip[0], run & (|uv_s), run & sev_s, ocp_fire};
  assign pready = 1'b1;
  // commands are ignored while the supplies are out of lockout range
  assign wr = psel & penable & pwrite & supplies_ok;
  assign rd_ok = (paddr == vss_pkg::REG_CTRL) || (paddr == vss_pkg::REG_TARGET) ||
                 (paddr == vss_pkg::REG_STATUS) || (paddr == vss_pkg::REG_IRQ_STAT) ||
                 (paddr == vss_pkg::REG_IRQ_MASK) || (paddr == vss_pkg::REG_REF) ||
                 (paddr == vss_pkg::REG_CFG);
  assign pslverr = psel & penable & ~rd_ok;
  assign irq = |(irq_stat_q & irq_mask_q);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      vss_pkg::REG_CTRL: rd_mux[vss_pkg::SLEW_W-1:0] = slew_q;
      vss_pkg::REG_TARGET: rd_mux[vss_pkg::REF_W-1:0] = target_q;
      vss_pkg::REG_STATUS: rd_mux[10:0] = {ov_lat, drv_s, en_s, supplies_ok, rdy_q,
                                           2'b00, state_q};
      vss_pkg::REG_IRQ_STAT: rd_mux[vss_pkg::IRQ_W-1:0] = irq_stat_q;
      vss_pkg::REG_IRQ_MASK: rd_mux[vss_pkg::IRQ_W-1:0] = irq_mask_q;
      vss_pkg::REG_REF: rd_mux[15:0] = {ref_aux, ref_main};
      vss_pkg::REG_CFG: rd_mux[vss_pkg::CFG_W-1:0] = cfg_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slew_q <= vss_pkg::SLEW_RST;
      target_q <= vss_pkg::TARGET_RST;
      irq_mask_q <= '0;
      irq_stat_q <= '0;
      prdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      if (wr && paddr == vss_pkg::REG_CTRL)
        slew_q <= pwdata[vss_pkg::CTRL_SLEW_LSB +: vss_pkg::SLEW_W];
      if (wr && paddr == vss_pkg::REG_TARGET)
        target_q <= pwdata[vss_pkg::REF_W-1:0];
      if (wr && paddr == vss_pkg::REG_IRQ_MASK)
        irq_mask_q <= pwdata[vss_pkg::IRQ_W-1:0];
      // set wins over write-one-to-clear
      irq_stat_q <= (irq_stat_q & ~((wr && paddr == vss_pkg::REG_IRQ_STAT) ?
                     pwdata[vss_pkg::IRQ_W-1:0] : '0)) | irq_ev;
      if (psel && !penable && !pwrite)
        prdata <= supplies_ok ? rd_mux : 32'h0000_0000;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_hold_driver;
    @(posedge pclk) disable iff (!presetn)
    (state_q == ST_IDLE && !drv_s && ce) |=> state_q != ST_SOFT;
  endproperty
  a_hold_driver: assert property (p_hold_driver) else $error("start while driver low");

  property p_mid_disabled;
    @(posedge pclk) disable iff (!presetn)
    (state_q == ST_IDLE && !(|ov_lat)) |-> (phase_main == 6'h15 && phase_aux == 4'h5);
  endproperty
  a_mid_disabled: assert property (p_mid_disabled) else $error("phase not mid");

  property p_severe;
    @(posedge pclk) disable iff (!presetn)
    (run && sev_s && ce && supplies_ok) |=> state_q == ST_OCP_OFF;
  endproperty
  a_severe: assert property (p_severe) else $error("no immediate shutdown");

  property p_ocp_hold;
    @(posedge pclk) disable iff (!presetn)
    (state_q == ST_OCP_OFF && supplies_ok && !en_toggle) |=> state_q == ST_OCP_OFF;
  endproperty
  a_ocp_hold: assert property (p_ocp_hold) else $error("left latch-off");

  property p_lockout;
    @(posedge pclk) disable iff (!presetn)
    (!supplies_ok && ce) |=> (state_q == ST_LOCKOUT && !drv_en_q);
  endproperty
  a_lockout: assert property (p_lockout) else $error("ran under lockout");

  property p_uv_ready;
    @(posedge pclk) disable iff (!presetn)
    (|uv_s && ce) |=> !regulator_ready;
  endproperty
  a_uv_ready: assert property (p_uv_ready) else $error("ready despite undervoltage");

  property p_ref_monotonic;
    @(posedge pclk) disable iff (!presetn)
    (starting && !(|ov_lat) && $past(starting)) |-> ref_main >= $past(ref_main);
  endproperty
  a_ref_monotonic: assert property (p_ref_monotonic) else $error("ramp fell");
  property p_drive_line;
    @(posedge pclk) disable iff (!presetn)
    (state_q == ST_RUN) |-> !driver_ready_line_oe;
  endproperty
  a_drive_line: assert property (p_drive_line) else $error("line not released");
endmodule

/* dv/vss_drv_model.sv */
`timescale 1ns/10ps
// ************************************************************
// gate driver on the shared ready line
// ************************************************************
module vss_drv_model #(
  parameter int HOLD = 24
) (
  // clock
  input wire logic pclk,
  // driver supply state from the bench
  input wire logic supply_ok,
  // open drain pull on the line
  output logic pull_low
);
  int cnt = HOLD;
  // minimum hold-off restarts on every supply dip
  always @(posedge pclk)
  begin
    if (!supply_ok)
      cnt <= HOLD;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  assign pull_low = !supply_ok || (cnt != 0);
endmodule

/* dv/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, err, vcc_ok = 0, rs = 0, enable = 0, drv_ok = 1, pull, line;
  logic ilim_trip = 0, ilim_severe = 0, oe, o, regulator_ready, irq;
  logic [1:0] uv_trip = 0, ov_diff = 0, ov_current_sense_reference = 0, ov_start = 0, above_ov = 0;
  logic [4:0] pwm_req = 0;
  logic [5:0] phase_main;
  logic [3:0] phase_aux;
  int n_mismatch = 0, tests_run = 0;
  always #4 pclk = ~pclk;
  // pulled up when neither party pulls low
  assign line = (oe ? o : 1'b1) && !pull;
  vss_drv_model vss_drv_model_inst (.pclk(pclk), .supply_ok(drv_ok), .pull_low(pull));
  vss_top vss_top_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .vcc_ok(vcc_ok), .ramp_supply_sense(rs),
    .enable(enable), .cfg_pins(8'h5a), .driver_ready_line_i(line), .driver_ready_line_o(o),
    .driver_ready_line_oe(oe), .ilim_trip(ilim_trip), .ilim_severe(ilim_severe),
    .uv_trip(uv_trip), .ov_diff(ov_diff), .ov_current_sense_reference(ov_current_sense_reference), .ov_start(ov_start),
    .above_ov(above_ov), .pwm_req(pwm_req), .phase_main(phase_main), .phase_aux(phase_aux),
    .regulator_ready(regulator_ready), .irq(irq));
  // ************************************************************
  // checks and apb
  // ************************************************************
  task conclude();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // read data and error are taken at the edge that sees pready high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      conclude();
    end
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input int lim);
    int i;
    i = 0;
    do
    begin
      apb(0, a, 0);
      i++;
    end while ((r & m) !== e && i < lim);
    chk(r & m, e);
    if ((r & m) !== e)
      conclude();
  endtask
  task tend(input string s);
    $display("test %s done", s);
  endtask
  task run_up();
    enable <= 1;
    wreg(vss_pkg::REG_STATUS, 7, 4, 200);
  endtask
  task off();
    enable <= 0;
    wreg(vss_pkg::REG_STATUS, 7, 2, 20);
  endtask
  // ************************************************************
  // sequence
  // ************************************************************
  initial
  begin
    repeat (2) @(posedge pclk);
    chk(phase_main, 6'h15);
    chk(phase_aux, 4'h5);
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    enable <= 1;
    apb(1, vss_pkg::REG_TARGET, 32'h08);
    apb(0, vss_pkg::REG_TARGET, 0);
    chk(r, 0);
    repeat (10) @(posedge pclk);
    chk({o, oe}, 1);
    chk(phase_main, 6'h15);
    enable <= 0;
    tend("lockout");
    vcc_ok <= 1;
    rs <= 1;
    wreg(vss_pkg::REG_STATUS, 7, 2, 30);
    apb(0, vss_pkg::REG_CFG, 0);
    chk(r, 32'h5a);
    apb(0, vss_pkg::REG_TARGET, 0);
    chk(r, 32'h80);
    chk({phase_main, phase_aux}, 10'h155);
    apb(0, 8'h40, 0);
    chk(err, 1);
    apb(1, vss_pkg::REG_TARGET, 32'h08);
    apb(1, vss_pkg::REG_CTRL, 32'h0f);
    apb(1, vss_pkg::REG_IRQ_MASK, 0);
    tend("capture");
    drv_ok <= 0;
    enable <= 1;
    repeat (30) @(posedge pclk);
    wreg(vss_pkg::REG_STATUS, 7, 2, 1);
    chk(phase_main, 6'h15);
    drv_ok <= 1;
    wreg(vss_pkg::REG_STATUS, 7, 3, 30);
    chk(oe, 0);
    chk(phase_aux, 4'h5);
    wreg(vss_pkg::REG_STATUS, 7, 4, 200);
    apb(0, vss_pkg::REG_REF, 0);
    chk(r, 32'h0808);
    pwm_req <= 5'h1f;
    repeat (4) @(posedge pclk);
    chk({phase_main, phase_aux}, 10'h2aa);
    wreg(vss_pkg::REG_STATUS, 32'h20, 32'h20, 100);
    uv_trip <= 2'b10;
    wreg(vss_pkg::REG_STATUS, 32'h20, 0, 4);
    uv_trip <= 0;
    off();
    chk({phase_main, phase_aux}, 10'h155);
    tend("startup");
    run_up();
    ilim_trip <= 1;
    repeat (6000) @(posedge pclk);
    wreg(vss_pkg::REG_STATUS, 7, 4, 1);
    wreg(vss_pkg::REG_STATUS, 7, 5, 120);
    chk(phase_main, 6'h15);
    wreg(vss_pkg::REG_IRQ_STAT, 1, 1, 1);
    ilim_trip <= 0;
    repeat (20) @(posedge pclk);
    wreg(vss_pkg::REG_STATUS, 7, 5, 1);
    off();
    run_up();
    apb(1, vss_pkg::REG_IRQ_STAT, 32'h1f);
    apb(1, vss_pkg::REG_IRQ_MASK, 32'h02);
    ilim_severe <= 1;
    wreg(vss_pkg::REG_STATUS, 7, 5, 3);
    chk(irq, 1);
    ilim_severe <= 0;
    apb(1, vss_pkg::REG_IRQ_STAT, 32'h02);
    @(posedge pclk);
    chk(irq, 0);
    apb(1, vss_pkg::REG_IRQ_MASK, 0);
    off();
    tend("overcurrent");
    run_up();
    ov_diff <= 2'b01;
    above_ov <= 2'b01;
    repeat (5) @(posedge pclk);
    chk(regulator_ready, 0);
    chk(phase_main, 6'h00);
    ov_diff <= 0;
    above_ov <= 2'b01;
    repeat (5) @(posedge pclk);
    chk(phase_main, 6'h00);
    above_ov <= 0;
    repeat (4) @(posedge pclk);
    chk(phase_main, 6'h15);
    wreg(vss_pkg::REG_REF, 32'hff, 0, 100);
    chk(phase_main, 6'h00);
    ov_current_sense_reference <= 2'b10;
    above_ov <= 2'b10;
    repeat (5) @(posedge pclk);
    chk(phase_aux, 4'h0);
    ov_current_sense_reference <= 0;
    above_ov <= 0;
    pwm_req <= 0;
    off();
    chk(phase_main, 6'h15);
    enable <= 1;
    wreg(vss_pkg::REG_STATUS, 7, 3, 30);
    ov_diff <= 2'b01;
    repeat (5) @(posedge pclk);
    chk(phase_main, 6'h15);
    ov_start <= 2'b01;
    above_ov <= 2'b01;
    repeat (5) @(posedge pclk);
    chk(phase_main, 6'h00);
    ov_diff <= 0;
    ov_start <= 0;
    above_ov <= 0;
    vcc_ok <= 0;
    repeat (8) @(posedge pclk);
    chk({oe, phase_main}, 7'h55);
    tend("overvoltage");
    conclude();
  end
endmodule
